// ==== core/aimc_defs.vh ====
`ifndef AIMC_DEFS_VH
`define AIMC_DEFS_VH

// Register offsets on the internal register port
`define AIMC_ADDR_EVENT_STATUS 8'h03
`define AIMC_ADDR_DEVICE_STATUS 8'h04
`define AIMC_ADDR_IRQ_ENABLE 8'h06
`define AIMC_ADDR_OP_STATE_CTRL 8'h07
`define AIMC_ADDR_TAP_CTRL 8'h09

// Reset values
`define AIMC_RST_IRQ_ENABLE 8'h00
`define AIMC_RST_OP_STATE_CTRL 8'h00
`define AIMC_RST_TAP_CTRL 8'h00

// Interrupt enable fields
`define AIMC_IEN_TAP_MSB 5
`define AIMC_IEN_SAMPLE_BIT 7

// Operating-state control fields
`define AIMC_OPC_STATE_MSB 1
`define AIMC_OPC_WDOG_LOW_BIT 4
`define AIMC_OPC_WDOG_HIGH_BIT 5
`define AIMC_OPC_PUSH_PULL_BIT 6
`define AIMC_OPC_ACT_HIGH_BIT 7
`define AIMC_OPC_WMASK 8'hF3

// Operating-state codes
`define AIMC_STATE_STANDBY 2'h0
`define AIMC_STATE_WAKE 2'h1

// Tap control fields
`define AIMC_TAPC_GLOBAL_BIT 7
`define AIMC_TAPC_WMASK 8'hBF

// Device status fields
`define AIMC_DSTAT_WDOG_BIT 4

// Watchdog stall limit in sys_clk cycles (no figure given; plain default)
`define AIMC_WDOG_STALL_CYCLES 1000

`endif

// ==== core/aimc_bus_wdog.v ====
`include "aimc_defs.vh"

module aimc_bus_wdog #(
  parameter STALL_CYCLES = `AIMC_WDOG_STALL_CYCLES,
  parameter CNT_W = 16
) (
  input wire sys_clk, // System clock
  input wire reset, // Synchronous reset, active high
  input wire scl_level, // Serial clock line level
  input wire bus_busy, // Serial transfer in progress
  input wire low_en, // Low-stall detection enable
  input wire high_en, // High-stall detection enable
  output reg expire_reg // One-cycle expiry pulse
);

  reg [CNT_W-1:0] count_reg;
  reg last_level_reg;
  wire armed;
  wire at_limit;

  // High stall only counts inside a transfer, since an idle bus rests high
  assign armed = scl_level ? (high_en & bus_busy) : low_en;
  assign at_limit = (count_reg == STALL_CYCLES[CNT_W-1:0] - 16'h0001);

  // Count cycles the line rests at one level; restart on any edge
  always @(posedge sys_clk) begin
    if (reset) begin
      count_reg <= 16'h0000;
      last_level_reg <= 1'b1;
      expire_reg <= 1'b0;
    end else begin
      last_level_reg <= scl_level;
      expire_reg <= 1'b0;
      if (!armed || (scl_level != last_level_reg)) begin
        count_reg <= 16'h0000;
      end else if (at_limit) begin
        count_reg <= 16'h0000; // Re-arm so a long stall fires once per period
        expire_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

endmodule

// ==== core/aimc_ctrl.v ====
`include "aimc_defs.vh"

module aimc_ctrl #(
  parameter NUM_TAPS = 6,
  parameter WDOG_STALL_CYCLES = `AIMC_WDOG_STALL_CYCLES
) (
  input wire sys_clk, // 40 MHz system clock
  input wire reset, // Synchronous reset, active high
  input wire [7:0] reg_addr, // Register address from serial slave
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe, one cycle
  input wire reg_rd, // Read strobe, one cycle
  output reg [7:0] reg_rdata_reg, // Read data, valid cycle after strobe
  input wire [NUM_TAPS-1:0] tap_event, // Tap detector pulses
  input wire sample_event, // Sample acquired pulse
  input wire scl_level, // Serial clock line level
  input wire bus_busy, // Serial transfer in progress
  output reg slave_reset_reg, // Return serial slave to idle
  output reg [1:0] op_state_sel_reg, // Selected operating state
  output reg interrupt_out_pin_o_reg, // Interrupt pin output level
  output reg interrupt_out_pin_oe_n_reg // Interrupt pin drive, low drives
);

  reg [7:0] irq_enable_reg;
  reg [7:0] op_ctrl_reg;
  reg [7:0] tap_ctrl_reg;
  reg [NUM_TAPS-1:0] tap_flag_reg;
  reg sample_ready_flag_reg;
  reg bus_wdog_event_flag_reg;
  reg [7:0] rdata_next;
  wire [NUM_TAPS-1:0] tap_set;
  wire [NUM_TAPS-1:0] tap_irq_src;
  wire status_rd;
  wire dstat_rd;
  wire wdog_expire;
  wire irq_active;
  wire bus_wdog_low_stall_en;
  wire bus_wdog_high_stall_en;
  wire irq_push_pull_sel;
  wire irq_active_high_sel;
  wire sample_ready_irq_en;

  assign bus_wdog_low_stall_en = op_ctrl_reg[`AIMC_OPC_WDOG_LOW_BIT];
  assign bus_wdog_high_stall_en = op_ctrl_reg[`AIMC_OPC_WDOG_HIGH_BIT];
  assign irq_push_pull_sel = op_ctrl_reg[`AIMC_OPC_PUSH_PULL_BIT];
  assign irq_active_high_sel = op_ctrl_reg[`AIMC_OPC_ACT_HIGH_BIT];
  assign sample_ready_irq_en = irq_enable_reg[`AIMC_IEN_SAMPLE_BIT];
  assign status_rd = reg_rd && (reg_addr == `AIMC_ADDR_EVENT_STATUS);
  assign dstat_rd = reg_rd && (reg_addr == `AIMC_ADDR_DEVICE_STATUS);

  // Configuration writes; state register takes writes in any state
  always @(posedge sys_clk) begin
    if (reset) begin
      irq_enable_reg <= `AIMC_RST_IRQ_ENABLE;
      op_ctrl_reg <= `AIMC_RST_OP_STATE_CTRL;
      tap_ctrl_reg <= `AIMC_RST_TAP_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        `AIMC_ADDR_IRQ_ENABLE: irq_enable_reg <= reg_wdata & 8'hBF; // Bit 6 reserved
        // Bit 2 is host-kept zero and bit 3 reserved; neither is stored
        `AIMC_ADDR_OP_STATE_CTRL: op_ctrl_reg <= reg_wdata & `AIMC_OPC_WMASK;
        `AIMC_ADDR_TAP_CTRL: tap_ctrl_reg <= reg_wdata & `AIMC_TAPC_WMASK;
        default: irq_enable_reg <= irq_enable_reg;
      endcase
    end
  end

  // Tap flags only set when that direction's detection is switched on
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TAPS; gi = gi + 1) begin : g_tap
      assign tap_set[gi] = tap_event[gi] & tap_ctrl_reg[gi] &
                           tap_ctrl_reg[`AIMC_TAPC_GLOBAL_BIT];
      // Gated by the interrupt enable and the tap enables; the flag path never looks at the interrupt enable
      assign tap_irq_src[gi] = tap_flag_reg[gi] & irq_enable_reg[gi] &
                               tap_ctrl_reg[gi] & tap_ctrl_reg[`AIMC_TAPC_GLOBAL_BIT];
      // Read clears, but an event in the same cycle survives the clear
      always @(posedge sys_clk) begin
        if (reset) begin
          tap_flag_reg[gi] <= 1'b0;
        end else if (tap_set[gi]) begin
          tap_flag_reg[gi] <= 1'b1;
        end else if (status_rd) begin
          tap_flag_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Sample flag and watchdog flag, set wins over read-clear
  always @(posedge sys_clk) begin
    if (reset) begin
      sample_ready_flag_reg <= 1'b0;
      bus_wdog_event_flag_reg <= 1'b0;
    end else begin
      if (sample_event) begin
        sample_ready_flag_reg <= 1'b1;
      end else if (status_rd) begin
        sample_ready_flag_reg <= 1'b0;
      end
      if (wdog_expire) begin
        bus_wdog_event_flag_reg <= 1'b1;
      end else if (dstat_rd) begin
        bus_wdog_event_flag_reg <= 1'b0;
      end
    end
  end

  // Level interrupt: stays up until a status read clears every enabled flag
  assign irq_active = (|tap_irq_src) |
                      (sample_ready_flag_reg & sample_ready_irq_en);

  // Read mux; the status snapshot is the pre-clear value
  always @* begin
    rdata_next = 8'h00;
    case (reg_addr)
      `AIMC_ADDR_EVENT_STATUS: begin
        rdata_next[NUM_TAPS-1:0] = tap_flag_reg;
        rdata_next[7] = sample_ready_flag_reg;
      end
      `AIMC_ADDR_DEVICE_STATUS: begin
        rdata_next[`AIMC_DSTAT_WDOG_BIT] = bus_wdog_event_flag_reg;
        rdata_next[`AIMC_OPC_STATE_MSB:0] = op_state_sel_reg;
      end
      `AIMC_ADDR_IRQ_ENABLE: rdata_next = irq_enable_reg;
      `AIMC_ADDR_OP_STATE_CTRL: rdata_next = op_ctrl_reg;
      `AIMC_ADDR_TAP_CTRL: rdata_next = tap_ctrl_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Registered outputs: read data, state, slave reset, interrupt pad
  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata_reg <= 8'h00;
      op_state_sel_reg <= `AIMC_STATE_STANDBY;
      slave_reset_reg <= 1'b0;
      interrupt_out_pin_o_reg <= 1'b1;
      interrupt_out_pin_oe_n_reg <= 1'b1; // Released: default open drain, idle
    end else begin
      if (reg_rd) begin
        reg_rdata_reg <= rdata_next;
      end
      op_state_sel_reg <= op_ctrl_reg[`AIMC_OPC_STATE_MSB:0];
      slave_reset_reg <= wdog_expire;
      if (irq_push_pull_sel) begin
        // Push-pull: always driven, level follows polarity
        interrupt_out_pin_oe_n_reg <= 1'b0;
        interrupt_out_pin_o_reg <= irq_active ~^ irq_active_high_sel;
      end else begin
        // Open drain: only ever pulls low; pull-up gives the high level
        interrupt_out_pin_o_reg <= 1'b0;
        interrupt_out_pin_oe_n_reg <= irq_active ~^ irq_active_high_sel;
      end
    end
  end

  // Clock-line stall watchdog
  aimc_bus_wdog #(
    .STALL_CYCLES(WDOG_STALL_CYCLES),
    .CNT_W(16)
  ) u_wdog (
    .sys_clk(sys_clk),
    .reset(reset),
    .scl_level(scl_level),
    .bus_busy(bus_busy),
    .low_en(bus_wdog_low_stall_en),
    .high_en(bus_wdog_high_stall_en),
    .expire_reg(wdog_expire)
  );

endmodule

// ==== dv/aimc_props.sv ====
module aimc_props #(parameter NUM_TAPS = 6) (
  input logic sys_clk, reset, reg_wr, reg_rd, // Clock and strobes
  input logic [7:0] reg_addr, reg_wdata, reg_rdata_reg, // Register port
  input logic [NUM_TAPS-1:0] tap_event, // Tap pulses
  input logic sample_event, scl_level, bus_busy, slave_reset_reg, // Events, bus
  input logic [1:0] op_state_sel_reg, // State field
  input logic interrupt_out_pin_o_reg, interrupt_out_pin_oe_n_reg // Pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // Short aliases keep each property but dstat_state_a on one line
  wire oe_n = interrupt_out_pin_oe_n_reg;
  wire pin_o = interrupt_out_pin_o_reg;
  wire [1:0] wd_st = reg_wdata[1:0];
  wire wr7 = reg_wr && reg_addr == 8'h07;
  wire rd3 = reg_rd && reg_addr == 8'h03;
  wire quiet = !sample_event && !(|tap_event);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Mode write left alone one cycle, so the pad has time to follow it
  sequence wr7_hold(b); wr7 && reg_wdata[6] == b ##1 !wr7; endsequence
  sequence rd3_twice; rd3 && quiet ##1 rd3; endsequence
  rst_idle_a: assert property ($fell(reset) |-> oe_n && pin_o && op_state_sel_reg == 2'h0)
    else $error("pad or state not idle after reset");
  state_wr_a: assert property (wr7 |-> ##2 op_state_sel_reg == $past(wd_st, 2))
    else $error("state field not taken");
  push_pull_a: assert property (wr7_hold(1'b1) |=> !oe_n)
    else $error("push-pull pad not driven");
  open_drain_a: assert property (wr7_hold(1'b0) |=> !pin_o)
    else $error("open-drain pad drives high");
  ien_resv_a: assert property (reg_rd && reg_addr == 8'h06 |=> !reg_rdata_reg[6])
    else $error("reserved enable bit reads one");
  dstat_state_a: assert property (reg_rd && reg_addr == 8'h04
    |=> reg_rdata_reg[1:0] == $past(op_state_sel_reg))
    else $error("device status state mismatch");
  evt_clear_a: assert property (rd3_twice |=> reg_rdata_reg == 8'h00)
    else $error("status read did not clear flags");
  wdog_pulse_a: assert property (slave_reset_reg |=> !slave_reset_reg)
    else $error("slave reset longer than one cycle");
endmodule

// ==== dv/aimc_host.sv ====
module aimc_host (
  input logic o, oe_n, act_high, // Pad drive, polarity the host set
  output logic pad, irq // Wire level, decoded request
);
  timeunit 1ns;
  timeprecision 1ps;
  // External pull-up wins whenever the device lets go of the pin
  assign pad = oe_n ? 1'b1 : o;
  assign irq = pad == act_high;
endmodule

// ==== dv/test_aimc_ctrl.sv ====
module test_aimc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, sample_event = 0;
  logic scl_level = 1, bus_busy = 0, act_high = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [5:0] tap_event = 6'h00;
  logic [7:0] modes [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
  wire [7:0] reg_rdata_reg;
  wire [1:0] op_state_sel_reg;
  wire slave_reset_reg, interrupt_out_pin_o_reg, interrupt_out_pin_oe_n_reg, pad, irq;
  int error_cnt = 0, total_checks = 0, cyc = 0, n = 0;
  always #12.5 sys_clk = ~sys_clk;
  aimc_ctrl #(.WDOG_STALL_CYCLES(8)) dut_u (.*);
  aimc_host host_u (.o(interrupt_out_pin_o_reg), .oe_n(interrupt_out_pin_oe_n_reg),
    .act_high(act_high), .pad(pad), .irq(irq));
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, exp, seen);
    end
  endtask
  task automatic ck_irq(input logic e);
    chk("irq", {7'h00, irq}, {7'h00, e});
  endtask
  // Accesses start at a falling edge; the tail lets the pad settle
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk("rdata", reg_rdata_reg, e);
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic ev(input logic [5:0] t, input logic s);
    tap_event = t;
    sample_event = s;
    @(negedge sys_clk);
    tap_event = 6'h00;
    sample_event = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  // Holds the serial clock at one level and counts slave resets
  task automatic stall(input logic lvl, input logic [7:0] e);
    n = 0;
    scl_level = lvl;
    bus_busy = 1'b1;
    repeat (12) @(negedge sys_clk);
    scl_level = 1'b1;
    bus_busy = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("slave rst", 8'(n), e);
  endtask
  // Hang guard, and the slave reset pulse count
  always @(posedge sys_clk) begin
    cyc++;
    if (slave_reset_reg === 1'b1) begin
      n++;
    end
    if (cyc == 3000) begin
      error_cnt++;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    chk("pad", {7'h00, pad}, 8'h01);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'hBF);
    wr(8'h07, 8'hF1);
    rd(8'h07, 8'hF1);
    rd(8'h04, 8'h01);
    wr(8'h07, 8'h00);
    rd(8'h04, 8'h00);
    wr(8'h06, 8'h80);
    foreach (modes[i]) begin
      act_high = modes[i][7];
      wr(8'h07, modes[i]);
      ck_irq(1'b0);
      ev(6'h00, 1'b1);
      ck_irq(1'b1);
      rd(8'h03, 8'h80);
      ck_irq(1'b0);
    end
    wr(8'h06, 8'h00);
    ev(6'h00, 1'b1);
    ck_irq(1'b0);
    rd(8'h03, 8'h80);
    act_high = 1'b0;
    wr(8'h07, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(8'h09, 8'h80 | (8'h01 << i));
      wr(8'h06, 8'h01 << i);
      ev(6'h01 << i, 1'b0);
      ck_irq(1'b1);
      rd(8'h03, 8'h01 << i);
      ck_irq(1'b0);
    end
    wr(8'h09, 8'h80);
    wr(8'h06, 8'h01);
    ev(6'h01, 1'b1);
    ck_irq(1'b0);
    reg_addr = 8'h03;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    chk("1st read", reg_rdata_reg, 8'h80);
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk("2nd read", reg_rdata_reg, 8'h00);
    wr(8'h07, 8'h10);
    stall(1'b0, 8'h01);
    rd(8'h04, 8'h10);
    rd(8'h04, 8'h00);
    stall(1'b1, 8'h00);
    wr(8'h07, 8'h20);
    stall(1'b1, 8'h01);
    stall(1'b0, 8'h00);
    rd(8'h04, 8'h10);
    end_sim;
  end
endmodule
bind aimc_ctrl aimc_props #(.NUM_TAPS(NUM_TAPS)) chk_u (.*);
